// ==== common/wdrc_pkg.sv ====
// Constants shared by the watchdog and reset-cause unit.
// Function
// R01 - Set test-port reset flag, bit 4, on test-port scan reset.
// R02 - Set watchdog reset flag, bit 3, on watchdog timeout reset.
// R03 - Set brown-out reset flag, bit 2, on brown-out reset.
// R04 - Set external reset flag, bit 1, on external pin reset.
// R05 - Power-on clears flags 4..1; software writing zero clears any one.
// R06 - Power-on sets flag bit 0; only a software zero write clears it.
// R07 - Software reads then clears reset causes early after start-up.
// R08 - Watchdog counts ticks of its own nominal 1 MHz oscillator.
// R09 - Restart command returns the watchdog count to zero.
// R10 - Count returns to zero when disabled and on any chip reset.
// R11 - Enabled watchdog reaching its period without restart resets the chip.
// R12 - Prescale code 0..7 selects 16,384 cycles doubled per step.
// R13 - Control bits 7 to 5 read as zero.
// R14 - Turn-off enable clears itself four clock cycles after being set.
// R15 - Enable writes one; zero disables only while turn-off enable is one.
// R16 - Software writes both bits, then enable zero within four cycles.
// R17 - Reference on with brown-out fuse, comparator bandgap, or converter.
// R18 - Software waits up to 70 us reference start-up before use.
// R19 - Timeout makes a one-cycle reset pulse; delay starts at its fall.
// R20 - Restart, enable, prescale and timeout cross domains safely.
package wdrc_pkg;

    localparam int unsigned ADDR_W          = 8;
    localparam int unsigned DATA_W          = 32;

    localparam logic [7:0]  OFS_RESET_CAUSE = 8'h00;
    localparam logic [7:0]  OFS_WDT_CTRL    = 8'h04;
    localparam logic [7:0]  OFS_WDT_RESTART = 8'h08;
    localparam logic [7:0]  OFS_REF_CTRL    = 8'h0C;

    localparam int unsigned CAUSE_POR       = 0;
    localparam int unsigned CAUSE_EXT       = 1;
    localparam int unsigned CAUSE_BOD       = 2;
    localparam int unsigned CAUSE_WDT       = 3;
    localparam int unsigned CAUSE_TAP       = 4;
    localparam logic [4:0]  CAUSE_RESET     = 5'h01;

    localparam int unsigned CTRL_PRESC_LSB  = 0;
    localparam int unsigned CTRL_PRESC_W    = 3;
    localparam int unsigned CTRL_WDE        = 3;
    localparam int unsigned CTRL_TOE        = 4;
    localparam logic [4:0]  CTRL_RESET      = 5'h00;

    localparam int unsigned REF_COMPARATOR_BANDGAP_SELECT        = 0;
    localparam int unsigned REF_ADC_EN      = 1;
    localparam int unsigned REF_ON          = 2;

    localparam int unsigned TOE_CYCLES      = 4;
    localparam logic [2:0]  TOE_LOAD        = 3'(TOE_CYCLES - 1);

    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned WDT_OSC_HZ      = 1_000_000;
    localparam int unsigned OSC_DIV         = CLK_HZ / WDT_OSC_HZ;

    localparam int unsigned WDT_BASE_CYCLES = 16_384;
    localparam int unsigned CNT_W           = 22;

endpackage : wdrc_pkg

// ==== design/wdrc_osc_div.sv ====
// Divider that stands in for the watchdog oscillator as a tick enable.
`timescale 1ns/10ps
`default_nettype none
module wdrc_osc_div
    import wdrc_pkg::*;
#(
    parameter int unsigned DIV = OSC_DIV
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output var  logic tick_q
);

    localparam int unsigned    DW       = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [DW-1:0]  DIV_LAST = DW'(DIV - 1);

    logic [DW-1:0] div_q;

    if (DIV < 1) begin : g_bad_div
        $error("wdrc_osc_div: DIV must be at least one");
    end

    // Free running: restarts never touch it, so a tick keeps its spacing.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (div_q == DIV_LAST) begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

endmodule : wdrc_osc_div
`default_nettype wire

// ==== design/wdrc_top.sv ====
// Watchdog timer, reset-cause register and reference enable behind APB.
`timescale 1ns/10ps
`default_nettype none
module wdrc_top
    import wdrc_pkg::*;
#(
    parameter int unsigned BASE_CYCLES = WDT_BASE_CYCLES,
    parameter int unsigned DIV         = OSC_DIV
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output var  logic [DATA_W-1:0] prdata_q,
    output var  logic              pready_q,
    output var  logic              pslverr_q,
    input  wire logic              ext_reset_in,
    input  wire logic              bod_reset_in,
    input  wire logic              testport_reset_in,
    input  wire logic              brownout_detect_enable_fuse,
    output var  logic              wdt_reset_q,
    output var  logic              ref_enable_q,
    output var  logic              wdt_running_q
);

    localparam logic [CNT_W-1:0] BASE_LAST = CNT_W'(BASE_CYCLES - 1);

    if (BASE_CYCLES < 2 || (BASE_CYCLES << 7) > (1 << (CNT_W - 1))) begin : g_bad_base
        $error("wdrc_top: BASE_CYCLES does not fit the watchdog counter");
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction : hit

    logic              acc;
    logic              wr;
    logic              wr_cause;
    logic              wr_ctrl;
    logic              wr_restart;
    logic              wr_ref;
    logic              mapped;
    logic              cause_clr_por;
    logic              chip_rst;
    logic              tick;
    logic              timeout;
    logic [DATA_W-1:0] rdata;

    logic [4:0]        cause_q;
    logic              wde_q;
    logic              toe_q;
    logic [2:0]        toe_cnt_q;
    logic [2:0]        presc_q;
    logic [CNT_W-1:0]  count_q;
    logic              comparator_bandgap_select_q;
    logic              adc_en_q;

    assign acc           = psel && penable && pready_q;
    assign wr            = acc && pwrite;
    assign wr_cause      = wr && hit(paddr, OFS_RESET_CAUSE);
    assign wr_ctrl       = wr && hit(paddr, OFS_WDT_CTRL);
    assign wr_restart    = wr && hit(paddr, OFS_WDT_RESTART);
    assign wr_ref        = wr && hit(paddr, OFS_REF_CTRL);
    assign mapped        = hit(paddr, OFS_RESET_CAUSE) || hit(paddr, OFS_WDT_CTRL)
                        || hit(paddr, OFS_WDT_RESTART) || hit(paddr, OFS_REF_CTRL);
    assign cause_clr_por = wr_cause && !pwdata[CAUSE_POR];
    assign chip_rst      = ext_reset_in || bod_reset_in || testport_reset_in || wdt_reset_q;

    always_comb begin
        rdata = '0;
        if (hit(paddr, OFS_RESET_CAUSE)) begin
            rdata[4:0] = cause_q;
        end else if (hit(paddr, OFS_WDT_CTRL)) begin
            // Bits 7 to 5 stay zero from the default above.  [R13]
            rdata[CTRL_TOE]                             = toe_q;
            rdata[CTRL_WDE]                             = wde_q;
            rdata[CTRL_PRESC_LSB +: CTRL_PRESC_W]       = presc_q;
        end else if (hit(paddr, OFS_REF_CTRL)) begin
            rdata[REF_COMPARATOR_BANDGAP_SELECT]   = comparator_bandgap_select_q;
            rdata[REF_ADC_EN] = adc_en_q;
            rdata[REF_ON]     = ref_enable_q;
        end
    end

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            if (psel && penable && !pready_q) begin
                prdata_q <= pwrite ? '0 : rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Reset-cause flags. A source that fires in the cycle of a zero write wins.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_q <= CAUSE_RESET; // [R05] [R06]
        end else begin
            if (wr_cause) begin
                cause_q <= cause_q & pwdata[4:0]; // [R05] [R06]
            end
            if (testport_reset_in) begin
                cause_q[CAUSE_TAP] <= 1'b1; // [R01]
            end
            if (timeout) begin
                cause_q[CAUSE_WDT] <= 1'b1; // [R02]
            end
            if (bod_reset_in) begin
                cause_q[CAUSE_BOD] <= 1'b1; // [R03]
            end
            if (ext_reset_in) begin
                cause_q[CAUSE_EXT] <= 1'b1; // [R04]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Watchdog control. A chip reset returns the control register to zero.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wde_q   <= CTRL_RESET[CTRL_WDE];
            presc_q <= CTRL_RESET[CTRL_PRESC_LSB +: CTRL_PRESC_W];
        end else if (chip_rst) begin
            wde_q   <= 1'b0;
            presc_q <= '0;
        end else if (wr_ctrl) begin
            presc_q <= pwdata[CTRL_PRESC_LSB +: CTRL_PRESC_W];
            // A zero only sticks while the old turn-off enable is still set.
            if (pwdata[CTRL_WDE] || toe_q) begin
                wde_q <= pwdata[CTRL_WDE]; // [R15]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            toe_q     <= CTRL_RESET[CTRL_TOE];
            toe_cnt_q <= '0;
        end else if (chip_rst) begin
            toe_q     <= 1'b0;
            toe_cnt_q <= '0;
        end else if (wr_ctrl && pwdata[CTRL_TOE]) begin
            toe_q     <= 1'b1;
            toe_cnt_q <= TOE_LOAD; // [R14]
        end else if (toe_q) begin
            if (toe_cnt_q == '0) begin
                toe_q <= 1'b0; // [R14]
            end else begin
                toe_cnt_q <= toe_cnt_q - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Watchdog counter on the oscillator tick.

    wdrc_osc_div #(
        .DIV     (DIV)
    ) u_osc (
        .pclk    (pclk),
        .presetn (presetn),
        .tick_q  (tick) // [R08]
    );

    // The oscillator is modelled as a tick in the bus clock domain, so control and
    // timeout cross no clock boundary; a real second clock would need synchronisers. [R20]
    assign timeout = wde_q && tick && (count_q == (BASE_LAST << presc_q | ((CNT_W'(1) << presc_q)
                     - CNT_W'(1)))); // [R11] [R12]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= '0;
        end else if (chip_rst || !wde_q || timeout) begin
            count_q <= '0; // [R10]
        end else if (wr_restart) begin
            count_q <= '0; // [R09]
        end else if (tick) begin
            count_q <= count_q + 1'b1;
        end
    end

    // The pulse lasts one clock; the external delay timer starts on its fall.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_reset_q   <= 1'b0;
            wdt_running_q <= 1'b0;
        end else begin
            wdt_reset_q   <= timeout; // [R11] [R19]
            wdt_running_q <= wde_q && !chip_rst;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Reference enable. Start-up settling is left to software.

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comparator_bandgap_select_q   <= 1'b0;
            adc_en_q <= 1'b0;
        end else if (chip_rst) begin
            comparator_bandgap_select_q   <= 1'b0;
            adc_en_q <= 1'b0;
        end else if (wr_ref) begin
            comparator_bandgap_select_q   <= pwdata[REF_COMPARATOR_BANDGAP_SELECT];
            adc_en_q <= pwdata[REF_ADC_EN];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_enable_q <= 1'b0;
        end else begin
            ref_enable_q <= brownout_detect_enable_fuse || comparator_bandgap_select_q || adc_en_q; // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic ref_req;
    logic wde_keep;
    logic wde_drop;
    logic toe_end;

    assign ref_req  = brownout_detect_enable_fuse || comparator_bandgap_select_q || adc_en_q;
    assign wde_keep = wr_ctrl && !pwdata[CTRL_WDE] && !toe_q && wde_q && !chip_rst;
    assign wde_drop = wr_ctrl && !pwdata[CTRL_WDE] && toe_q && !chip_rst;
    assign toe_end  = toe_q && (toe_cnt_q == '0) && !(wr_ctrl && pwdata[CTRL_TOE]);

    chk_toe_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        $rose(toe_q) |-> toe_q [*4] ##1 (!toe_q || $past(wr_ctrl)))
        else $error("turn-off enable did not hold for four cycles");

    chk_toe_expire: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
        toe_end |=> !toe_q)
        else $error("turn-off enable did not expire");

    chk_wde_guard: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        wde_keep |=> wde_q)
        else $error("watchdog disabled without turn-off enable");

    chk_wde_off: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        wde_drop |=> !wde_q ##1 (count_q == '0))
        else $error("guarded disable did not stop and clear the watchdog");

    chk_poweron_reset_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn) // [R06]
        $fell(cause_q[CAUSE_POR]) |-> $past(cause_clr_por))
        else $error("power-on flag cleared without a zero write");

    chk_watchdog_reset_flag_timeout: assert property (@(posedge pclk) disable iff (!presetn) // [R02]
        wdt_reset_q |-> cause_q[CAUSE_WDT] ##1 (!wdt_reset_q && !wde_q))
        else $error("watchdog pulse not one cycle or flag missing");

    chk_restart_clear: assert property (@(posedge pclk) disable iff (!presetn) // [R09]
        wr_restart |=> (count_q == '0))
        else $error("restart did not clear the count");

    chk_chip_reset: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        ext_reset_in |=> !wde_q && (count_q == '0) && cause_q[CAUSE_EXT])
        else $error("chip reset did not clear watchdog or set flag");

    chk_ref_follow: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
        ##1 (ref_enable_q == $past(ref_req)))
        else $error("reference enable does not follow its sources");

    chk_bus_ready: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_q) |=> pready_q ##1 !pready_q)
        else $error("bus ready not one cycle after the wait state");

    cov_timeout: cover property (@(posedge pclk) disable iff (!presetn) wdt_reset_q);
    cov_disable: cover property (@(posedge pclk) disable iff (!presetn) $fell(wde_q) && !chip_rst);
    cov_por_clear: cover property (@(posedge pclk) disable iff (!presetn) cause_clr_por);
    cov_set_vs_clear: cover property (@(posedge pclk) disable iff (!presetn)
        wr_cause && !pwdata[CAUSE_EXT] && ext_reset_in);

endmodule : wdrc_top
`default_nettype wire

// ==== tb/wdrc_top_tb_top.sv ====
// Self-checking bench for the watchdog and reset-cause unit.
`timescale 1ns/10ps
`default_nettype none
module wdrc_top_tb_top
    import wdrc_pkg::*;
;
    // Short counts keep all eight prescale codes inside a brief run.
    localparam int unsigned BASE = 16;
    localparam int unsigned DV   = 2;
    localparam int          TOL  = 8;

    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    logic [2:0]        rsrc;
    logic              fuse;
    logic              wdt_reset_q;
    logic              ref_enable_q;
    logic              wdt_running_q;
    logic [DATA_W-1:0] rd;
    logic              er;
    int                err_count = 0;
    int                checks    = 0;
    int                hits      = 0;
    int                cyc       = 0;

    wdrc_top #(.BASE_CYCLES(BASE), .DIV(DV)) i_wdrc_top (
        .pclk                        (pclk),
        .presetn                     (presetn),
        .psel                        (psel),
        .penable                     (penable),
        .pwrite                      (pwrite),
        .paddr                       (paddr),
        .pwdata                      (pwdata),
        .prdata_q                    (prdata_q),
        .pready_q                    (pready_q),
        .pslverr_q                   (pslverr_q),
        .ext_reset_in                (rsrc[0]),
        .bod_reset_in                (rsrc[1]),
        .testport_reset_in           (rsrc[2]),
        .brownout_detect_enable_fuse (fuse),
        .wdt_reset_q                 (wdt_reset_q),
        .ref_enable_q                (ref_enable_q),
        .wdt_running_q               (wdt_running_q)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (wdt_reset_q === 1'b1) begin
            hits <= hits + 1;
        end
        if (cyc == 30000) begin
            err_count++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask : chk

    // Called at a rising edge; keep leaves psel up so the next setup follows at once.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input bit keep);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready_q !== 1'b1 && n < 20);
        rd = prdata_q;
        er = pslverr_q;
        penable <= 1'b0;
        if (n >= 20) begin
            chk("pready", 32'h1, 32'h0);
        end
        if (!keep) begin
            psel <= 1'b0;
            @(posedge pclk);
        end
    endtask : apb

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        apb(1'b0, OFS_RESET_CAUSE, 32'h0, 0);
        chk("cause_rst", 32'h01, rd);
        apb(1'b0, OFS_WDT_CTRL, 32'h0, 0);
        chk("ctrl_rst", 32'h00, rd);
    endtask : t_reset

    task automatic t_regs();
        apb(1'b1, OFS_WDT_CTRL, 32'hE7, 0);
        apb(1'b0, OFS_WDT_CTRL, 32'h0, 0);
        chk("ctrl_resv", 32'h07, rd);
        apb(1'b1, 8'h10, 32'hFF, 0);
        chk("unmapped_err", 32'h1, 32'(er));
        apb(1'b0, 8'h10, 32'h0, 0);
        chk("unmapped_rd", 32'h0, rd);
    endtask : t_regs

    task automatic t_ref();
        logic [2:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            fuse <= v[2];
            apb(1'b1, OFS_REF_CTRL, {30'h0, v[1:0]}, 0);
            repeat (2) @(posedge pclk);
            chk("ref_pin", 32'(|v), 32'(ref_enable_q));
            apb(1'b0, OFS_REF_CTRL, 32'h0, 0);
            chk("ref_reg", {29'h0, |v, v[1:0]}, rd);
        end
        fuse <= 1'b0;
        apb(1'b1, OFS_REF_CTRL, 32'h0, 0);
    endtask : t_ref

    // Each source is pulsed while the watchdog runs, so the chip reset is also seen.
    task automatic t_src();
        logic [31:0] b;
        logic [31:0] p;
        p = 32'h01;
        for (int k = 0; k < 3; k++) begin
            b = (k == 2) ? 32'h10 : 32'(1 << (k + 1));
            apb(1'b1, OFS_WDT_CTRL, 32'h0F, 0);
            rsrc <= 3'(1 << k);
            @(posedge pclk);
            rsrc <= 3'h0;
            repeat (2) @(posedge pclk);
            chk("src_stop", 32'h0, 32'(wdt_running_q));
            apb(1'b0, OFS_RESET_CAUSE, 32'h0, 0);
            chk("src_flag", p | b, rd);
            apb(1'b1, OFS_RESET_CAUSE, 32'h1F, 0);
            apb(1'b0, OFS_RESET_CAUSE, 32'h0, 0);
            chk("cause_w1", p | b, rd);
            apb(1'b1, OFS_RESET_CAUSE, 32'h0, 0);
            apb(1'b0, OFS_RESET_CAUSE, 32'h0, 0);
            chk("cause_w0", 32'h0, rd);
            p = 32'h0;
        end
        rsrc <= 3'h7;
        @(posedge pclk);
        rsrc <= 3'h0;
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_RESET_CAUSE, 32'h0, 0);
        chk("cause_por", 32'h01, rd);
    endtask : t_src

    task automatic t_tmo();
        int n;
        int e;
        for (int p = 0; p < 8; p++) begin
            apb(1'b1, OFS_RESET_CAUSE, 32'h0, 0);
            apb(1'b1, OFS_WDT_CTRL, 32'(8 + p), 0);
            e = int'(BASE << p) * int'(DV);
            n = 0;
            while (wdt_reset_q !== 1'b1 && n < 5000) begin
                @(posedge pclk);
                n++;
            end
            chk("tmo_len", 32'h1, 32'(n + TOL >= e && n <= e + TOL));
            @(posedge pclk);
            chk("tmo_pulse", 32'h0, 32'(wdt_reset_q));
            apb(1'b0, OFS_RESET_CAUSE, 32'h0, 0);
            chk("tmo_flag", 32'h08, rd);
            apb(1'b0, OFS_WDT_CTRL, 32'h0, 0);
            chk("tmo_ctrl", 32'h00, rd);
        end
    endtask : t_tmo

    task automatic t_restart();
        hits = 0;
        apb(1'b1, OFS_WDT_CTRL, 32'h08, 0);
        repeat (6) begin
            repeat (15) @(posedge pclk);
            apb(1'b1, OFS_WDT_RESTART, 32'h0, 0);
        end
        chk("restart_hits", 32'h0, 32'(hits));
        apb(1'b1, OFS_WDT_CTRL, 32'h0F, 0);
    endtask : t_restart

    task automatic t_off();
        apb(1'b1, OFS_WDT_CTRL, 32'h07, 0);
        apb(1'b0, OFS_WDT_CTRL, 32'h0, 0);
        chk("off_refused", 32'h0F, rd);
        apb(1'b1, OFS_WDT_CTRL, 32'h1F, 0);
        repeat (6) @(posedge pclk);
        apb(1'b0, OFS_WDT_CTRL, 32'h0, 0);
        chk("toe_expired", 32'h0F, rd);
        apb(1'b1, OFS_WDT_CTRL, 32'h07, 0);
        chk("off_late", 32'h1, 32'(wdt_running_q));
        apb(1'b1, OFS_WDT_CTRL, 32'h1F, 1);
        apb(1'b1, OFS_WDT_CTRL, 32'h07, 0);
        repeat (2) @(posedge pclk);
        chk("off_done", 32'h0, 32'(wdt_running_q));
        apb(1'b0, OFS_WDT_CTRL, 32'h0, 0);
        chk("off_ctrl", 32'h07, rd);
        chk("off_hits", 32'h0, 32'(hits));
    endtask : t_off

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = '0;
        pwdata  = '0;
        rsrc    = 3'h0;
        fuse    = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_regs();
        t_ref();
        t_src();
        t_tmo();
        t_restart();
        t_off();
        conclude();
    end

endmodule : wdrc_top_tb_top
`default_nettype wire
